// ### hdl/rcc_pkg.sv
// constants, carriers and field layout for the reset and clock control block
//
// Behaviour
// - power-on or brownout gives full reset incl debug
// - device held in reset while pin low
// - cause register: one sticky flag per source
// - lockup only sets its flag, no reset
// - any write to clear location clears causes
// - reach bit: pin/watchdog resets spare debug logic
// - watchdog off at reset, overflow resets, flags
// - locked watchdog accepts only counter clear
// - watchdog pauses while debugger attached
// - test pin high with reset pin low at power-up enters sticky test mode
// - system clock divisible by one through eight
// - 3-bit divider field n divides by n+1
// - control bit0 source select, bit4 rtc enable
// - write-one bits 3 and 2 start calibration
// - status reports calibration done and failure
// - status bits 0/1 show crystal stable
// - status bit 31 shows test pin level
// - interrupt enables bit1 fast, bit0 slow
// - any write to clock clear clears calibration status, interrupts
// - peripheral gates reset to 1, writes to gated watchdog dropped
// - peripheral clock follows divided system clock
// - control bit1 locks debug port until reset
// - boost on during crystal startup, off after
package rcc_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_RESET_CAUSE = 32'h4001_8000;
    localparam logic [31:0] ADDR_RESET_CAUSE_CLEAR = 32'h4001_8004;
    localparam logic [31:0] ADDR_HARDWARE_REVISION = 32'h4001_8008;
    localparam logic [31:0] ADDR_RESET_REACH = 32'h4001_800C;
    localparam logic [31:0] ADDR_WDOG_CONTROL = 32'h4001_8010;
    localparam logic [31:0] ADDR_WDOG_CLEAR = 32'h4001_8014;
    localparam logic [31:0] ADDR_CLOCK_CONTROL = 32'h4001_B000;
    localparam logic [31:0] ADDR_CLOCK_STATUS = 32'h4001_B004;
    localparam logic [31:0] ADDR_CLOCK_IRQ_ENABLE = 32'h4001_B008;
    localparam logic [31:0] ADDR_CLOCK_IRQ_CLEAR = 32'h4001_B00C;
    localparam logic [31:0] ADDR_PERIPH_GATE = 32'h4001_B010;
    localparam logic [31:0] ADDR_PRESCALER = 32'h4001_B014;
    // reset cause bit positions
    localparam int CAUSE_POR = 4;
    localparam int CAUSE_SOFT = 3;
    localparam int CAUSE_PIN = 2;
    localparam int CAUSE_WDOG = 1;
    localparam int CAUSE_LOCKUP = 0;
    localparam logic [4:0] CAUSE_RESET = 5'h10; // power-on flag set
    // clock control bit positions
    localparam int CTL_HS_SELECT = 0;
    localparam int CTL_DAP_LOCK = 1;
    localparam int CTL_CAL_SLOW = 2;
    localparam int CTL_CAL_FAST = 3;
    localparam int CTL_RTC_ENABLE = 4;
    // clock status bit positions
    localparam int STS_XTAL_FAST = 0;
    localparam int STS_XTAL_SLOW = 1;
    localparam int STS_SLOW_FAIL = 2;
    localparam int STS_SLOW_DONE = 3;
    localparam int STS_FAST_FAIL = 4;
    localparam int STS_FAST_DONE = 5;
    localparam int STS_TEST_PIN = 31;
    // interrupt enable and watchdog control bit positions
    localparam int IRQ_SLOW = 0;
    localparam int IRQ_FAST = 1;
    localparam int WDOG_ENABLE = 0;
    localparam int WDOG_LOCK = 1;
    localparam int GATE_WDOG = 10;
    // reset values
    localparam logic [31:0] PERIPH_GATE_RESET = 32'hFFFF_FFFF;
    localparam logic [2:0] PRESCALER_RESET = 3'h3;
    // timing
    localparam int CLK_HZ = 125_000_000;
    localparam int SLOW_HZ = 32_768;
    localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_HZ;
    localparam int RESET_PULSE_NS = 128;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // pins that arrive from outside the clock domain
    typedef struct packed {
        logic brownoutReset;
        logic externalResetPinN;
        logic factoryTestPin;
        logic xtalFastStable;
        logic xtalSlowStable;
    } rcc_pins_s;
endpackage

// ### hdl/rcc_top.sv
// reset source handling, watchdog and clock management with apb registers
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module rcc_top
    import rcc_pkg::*;
#(
    parameter int WDOG_WIDTH = 18,
    parameter logic [31:0] HW_REVISION = 32'h0000_0A01 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rcc_pins_s pinsIn,
    input wire logic softwareResetRequest,
    input wire logic lockupIn,
    input wire logic debuggerAttached,
    input wire logic calFastDone,
    input wire logic calFastFail,
    input wire logic calSlowDone,
    input wire logic calSlowFail,
    input wire logic xtalSlowRequest,
    output logic systemReset,
    output logic debugReset,
    output logic factoryTestMode,
    output logic first_digital_pin,
    output logic hsSourceSelect,
    output logic rtcEnable,
    output logic calFastStart,
    output logic calSlowStart,
    output logic clockIrq,
    output logic debugPortClockGate,
    output logic system_clock_divided,
    output logic [31:0] periphClockEnable,
    output logic boostFast,
    output logic boostSlow
);
    localparam logic [7:0] PULSE_LEN = 8'(RESET_PULSE_CYCLES);
    localparam logic [11:0] TICK_LAST = 12'(SLOW_TICK_CYCLES - 1);

    rcc_pins_s sync1, sync2, sync3, pins;
    logic [4:0] resetCause;
    logic reachSpareDebug;
    logic [1:0] wdogCtl;
    logic [WDOG_WIDTH-1:0] watchdog_counter;
    logic [11:0] tickCount;
    logic slowTick;
    logic [7:0] sysPulse, dbgPulse;
    logic startupSeen, porInternal;
    logic [4:0] clkCtl;
    logic [3:0] calStatus;
    logic [1:0] irqEnable, irqPending;
    logic [31:0] periphGate;
    logic [2:0] prescaler, divCount;
    logic wrAccess, setupPhase, wdogOverflow, brownoutEdge, brownoutLast;
    logic [31:0] next_rdata;
    logic next_err;

    // decode helper used by every write strobe
    function automatic logic wrHit(input logic [31:0] target);
        return wrAccess && (paddr == target);
    endfunction

    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pready && pwrite;

    // three-stage pin synchroniser, accepted once stages two and three agree
    always_ff @(posedge clk_sys) begin
        sync1 <= pinsIn;
        sync2 <= sync1;
        sync3 <= sync2;
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pins <= '{externalResetPinN: 1'b1, default: 1'b0};
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pins[i] <= sync3[i];
                end
            end
        end
    end

    // brownout edge: a new brownout starts one full reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            brownoutLast <= 1'b0;
        end else begin
            brownoutLast <= pins.brownoutReset;
        end
    end
    assign brownoutEdge = pins.brownoutReset && !brownoutLast;

    // reset cause flags; a clear in the same cycle loses to a new event
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            resetCause <= CAUSE_RESET;
        end else begin
            if (wrHit(ADDR_RESET_CAUSE_CLEAR)) begin
                resetCause <= '0;
            end
            if (brownoutEdge) begin
                resetCause[CAUSE_POR] <= 1'b1;
            end
            if (softwareResetRequest) begin
                resetCause[CAUSE_SOFT] <= 1'b1;
            end
            if (!pins.externalResetPinN) begin
                resetCause[CAUSE_PIN] <= 1'b1;
            end
            if (wdogOverflow) begin
                resetCause[CAUSE_WDOG] <= 1'b1;
            end
            if (lockupIn) begin
                resetCause[CAUSE_LOCKUP] <= 1'b1;
            end
        end
    end

    // reset reach control
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reachSpareDebug <= 1'b0;
        end else if (wrHit(ADDR_RESET_REACH)) begin
            reachSpareDebug <= pwdata[0];
        end
    end

    // reset pulse stretchers; lockup is deliberately absent here
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sysPulse <= PULSE_LEN;
            dbgPulse <= PULSE_LEN;
        end else begin
            if (brownoutEdge || softwareResetRequest || wdogOverflow) begin
                sysPulse <= PULSE_LEN;
            end else if (sysPulse != 8'h00) begin
                sysPulse <= sysPulse - 8'h01;
            end
            if (brownoutEdge || (wdogOverflow && !reachSpareDebug)) begin
                dbgPulse <= PULSE_LEN;
            end else if (dbgPulse != 8'h00) begin
                dbgPulse <= dbgPulse - 8'h01;
            end
        end
    end

    // reset outputs; pin reset holds for as long as the pin is low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            systemReset <= 1'b1;
            debugReset <= 1'b1;
        end else begin
            systemReset <= (sysPulse != 8'h00) || !pins.externalResetPinN
                || brownoutEdge || softwareResetRequest
                || wdogOverflow;
            debugReset <= (dbgPulse != 8'h00) || brownoutEdge
                || (!reachSpareDebug && (!pins.externalResetPinN
                || wdogOverflow));
        end
    end

    // factory test mode caught once after power-up; only srst leaves it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            startupSeen <= 1'b0;
            factoryTestMode <= 1'b0;
            porInternal <= 1'b1;
        end else begin
            porInternal <= dbgPulse != 8'h00;
            if (!startupSeen && sysPulse == 8'h01) begin
                startupSeen <= 1'b1;
                factoryTestMode <= pins.factoryTestPin
                    && !pins.externalResetPinN;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            first_digital_pin <= 1'b0;
        end else begin
            first_digital_pin <= factoryTestMode && porInternal;
        end
    end

    // slow-domain tick from a divider of the system clock
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tickCount <= '0;
            slowTick <= 1'b0;
        end else begin
            slowTick <= tickCount == TICK_LAST;
            tickCount <= (tickCount == TICK_LAST) ? 12'h000
                : tickCount + 12'h001;
        end
    end

    // watchdog control; writes dropped while its register clock is gated
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wdogCtl <= '0;
        end else if (wrHit(ADDR_WDOG_CONTROL) && !periphGate[GATE_WDOG]
                && !wdogCtl[WDOG_LOCK]) begin
            wdogCtl <= pwdata[1:0];
        end
    end

    // watchdog counter, paused under the debugger
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            watchdog_counter <= '0;
            wdogOverflow <= 1'b0;
        end else begin
            wdogOverflow <= 1'b0;
            if (wrHit(ADDR_WDOG_CLEAR) && !periphGate[GATE_WDOG]) begin
                watchdog_counter <= '0;
            end else if (wdogCtl[WDOG_ENABLE] && slowTick
                    && !debuggerAttached) begin
                watchdog_counter <= watchdog_counter + 1'b1;
                wdogOverflow <= &watchdog_counter;
            end
        end
    end

    // clock control; debug lock is set-only, calibration bits are pulses
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clkCtl <= '0;
            calFastStart <= 1'b0;
            calSlowStart <= 1'b0;
        end else begin
            calFastStart <= 1'b0;
            calSlowStart <= 1'b0;
            if (wrHit(ADDR_CLOCK_CONTROL)) begin
                clkCtl[CTL_HS_SELECT] <= pwdata[CTL_HS_SELECT];
                clkCtl[CTL_RTC_ENABLE] <= pwdata[CTL_RTC_ENABLE];
                if (pwdata[CTL_DAP_LOCK]) begin
                    clkCtl[CTL_DAP_LOCK] <= 1'b1;
                end
                calFastStart <= pwdata[CTL_CAL_FAST];
                calSlowStart <= pwdata[CTL_CAL_SLOW];
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hsSourceSelect <= 1'b0;
            rtcEnable <= 1'b0;
            debugPortClockGate <= 1'b0;
            boostFast <= 1'b0;
            boostSlow <= 1'b0;
        end else begin
            hsSourceSelect <= clkCtl[CTL_HS_SELECT];
            rtcEnable <= clkCtl[CTL_RTC_ENABLE];
            debugPortClockGate <= clkCtl[CTL_DAP_LOCK];
            boostFast <= clkCtl[CTL_HS_SELECT] && !pins.xtalFastStable;
            boostSlow <= xtalSlowRequest && !pins.xtalSlowStable;
        end
    end

    // calibration status, bits {fastDone, fastFail, slowDone, slowFail}
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            calStatus <= '0;
        end else begin
            if (wrHit(ADDR_CLOCK_IRQ_CLEAR)) begin
                calStatus <= '0;
            end
            if (calFastStart) begin
                calStatus[3:2] <= 2'h0;
            end
            if (calSlowStart) begin
                calStatus[1:0] <= 2'h0;
            end
            if (calFastDone) begin
                calStatus[3:2] <= {1'b1, calFastFail};
            end
            if (calSlowDone) begin
                calStatus[1:0] <= {1'b1, calSlowFail};
            end
        end
    end

    // interrupt enables and sticky pending bits
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqEnable <= '0;
        end else if (wrHit(ADDR_CLOCK_IRQ_ENABLE)) begin
            irqEnable <= pwdata[1:0];
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqPending <= '0;
            clockIrq <= 1'b0;
        end else begin
            if (wrHit(ADDR_CLOCK_IRQ_CLEAR)) begin
                irqPending <= '0;
            end
            if (calFastDone && irqEnable[IRQ_FAST]) begin
                irqPending[IRQ_FAST] <= 1'b1;
            end
            if (calSlowDone && irqEnable[IRQ_SLOW]) begin
                irqPending[IRQ_SLOW] <= 1'b1;
            end
            clockIrq <= |irqPending;
        end
    end

    // peripheral gates and prescaler
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            periphGate <= PERIPH_GATE_RESET;
            prescaler <= PRESCALER_RESET;
        end else begin
            if (wrHit(ADDR_PERIPH_GATE)) begin
                periphGate <= pwdata;
            end
            if (wrHit(ADDR_PRESCALER)) begin
                prescaler <= pwdata[2:0];
            end
        end
    end

    // divide-by-(n+1) enable; peripheral enables follow it
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            divCount <= '0;
            system_clock_divided <= 1'b0;
            periphClockEnable <= '0;
        end else begin
            divCount <= (divCount >= prescaler) ? 3'h0 : divCount + 3'h1;
            system_clock_divided <= divCount >= prescaler;
            periphClockEnable <= {32{divCount >= prescaler}}
                & ~periphGate;
        end
    end

    // apb read mux, latched in the setup phase
    always_comb begin
        next_rdata = '0;
        next_err = 1'b0;
        unique case (paddr)
            ADDR_RESET_CAUSE: next_rdata = {27'h0, resetCause};
            ADDR_HARDWARE_REVISION: next_rdata = HW_REVISION;
            ADDR_RESET_REACH: next_rdata = {31'h0, reachSpareDebug};
            ADDR_WDOG_CONTROL: next_rdata = {30'h0, wdogCtl};
            ADDR_CLOCK_CONTROL: next_rdata = {27'h0, clkCtl[4], 2'h0,
                clkCtl[1:0]};
            ADDR_CLOCK_STATUS: next_rdata = {pins.factoryTestPin, 25'h0,
                calStatus, pins.xtalSlowStable, pins.xtalFastStable};
            ADDR_CLOCK_IRQ_ENABLE: next_rdata = {30'h0, irqEnable};
            ADDR_PERIPH_GATE: next_rdata = periphGate;
            ADDR_PRESCALER: next_rdata = {29'h0, prescaler};
            ADDR_RESET_CAUSE_CLEAR, ADDR_WDOG_CLEAR,
            ADDR_CLOCK_IRQ_CLEAR: next_rdata = '0;
            default: next_err = 1'b1;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && next_err;
            if (setupPhase) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    // checks
    a_lockup_no_reset: assert property (@(posedge clk_sys) disable iff (srst)
        lockupIn && !softwareResetRequest && !wdogOverflow && !brownoutEdge
        && sysPulse == 8'h00 && pins.externalResetPinN
        |=> !systemReset && resetCause[CAUSE_LOCKUP])
        else $error("lockup caused a reset");
    a_pin_holds_reset: assert property (@(posedge clk_sys) disable iff (srst)
        !pins.externalResetPinN |=> systemReset)
        else $error("pin low without system reset");
    a_cause_clear_all: assert property (@(posedge clk_sys) disable iff (srst)
        wrHit(ADDR_RESET_CAUSE_CLEAR) && !lockupIn && !brownoutEdge
        && !softwareResetRequest && !wdogOverflow
        && pins.externalResetPinN |=> resetCause == 5'h00)
        else $error("cause clear missed");
    a_reach_spares_debug: assert property (@(posedge clk_sys)
        disable iff (srst) reachSpareDebug && dbgPulse == 8'h00
        && !brownoutEdge |=> !debugReset)
        else $error("debug reset despite reach bit");
    a_wdog_overflow: assert property (@(posedge clk_sys) disable iff (srst)
        wdogOverflow |=> systemReset && resetCause[CAUSE_WDOG])
        else $error("watchdog overflow without reset");
    a_wdog_locked: assert property (@(posedge clk_sys) disable iff (srst)
        wdogCtl[WDOG_LOCK] |=> $stable(wdogCtl))
        else $error("locked watchdog control changed");
    a_wdog_pause: assert property (@(posedge clk_sys) disable iff (srst)
        debuggerAttached && !wrHit(ADDR_WDOG_CLEAR)
        |=> $stable(watchdog_counter))
        else $error("watchdog counted under debugger");
    // a prescaler write inside the window legally reshapes the period
    a_div_period: assert property (@(posedge clk_sys)
        disable iff (srst || wrHit(ADDR_PRESCALER))
        system_clock_divided && $stable(prescaler) && prescaler == 3'h3
        |=> !system_clock_divided [*3] ##1 system_clock_divided)
        else $error("divider period wrong");
    a_dap_lock_stays: assert property (@(posedge clk_sys) disable iff (srst)
        clkCtl[CTL_DAP_LOCK] |=> clkCtl[CTL_DAP_LOCK])
        else $error("debug lock cleared without reset");
    a_irq_sticky: assert property (@(posedge clk_sys) disable iff (srst)
        calFastDone && irqEnable[IRQ_FAST] |-> ##2 clockIrq)
        else $error("calibration interrupt missing");
    a_gate_discard: assert property (@(posedge clk_sys) disable iff (srst)
        periphGate[GATE_WDOG] |=> $stable(wdogCtl))
        else $error("write to gated watchdog took effect");
    c_wdog_reset: cover property (@(posedge clk_sys) wdogOverflow);
    c_cal_irq: cover property (@(posedge clk_sys) clockIrq);
    c_pin_reset: cover property (@(posedge clk_sys)
        !pins.externalResetPinN ##1 pins.externalResetPinN);
endmodule

// ### verif/test_reset_and_clock_control.sv
// self-checking bench for the reset and clock control block
`timescale 1ns/10ps
module test_reset_and_clock_control;
    import rcc_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, periphClockEnable;
    logic pready, pslverr, err, softReq = 1'b0, lockup = 1'b0;
    logic calFD = 1'b0, calFF = 1'b0, calSD = 1'b0, dbg = 1'b0;
    logic systemReset, debugReset, hsSourceSelect, rtcEnable, calFastStart;
    logic clockIrq, debugPortClockGate, system_clock_divided, boostFast;
    rcc_pins_s pins = 5'h08; // reset pin released, crystals not stable
    int fails = 0, checks = 0, cyc = 0, startCnt = 0, divCnt = 0, perCnt = 0;
    int sDiv, sPer, sStart;

    rcc_top #(.WDOG_WIDTH(4)) u_dut (.clk_sys(clk_sys), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinsIn(pins), .softwareResetRequest(softReq),
        .lockupIn(lockup), .debuggerAttached(dbg), .calFastDone(calFD),
        .calFastFail(calFF), .calSlowDone(calSD), .calSlowFail(1'b0),
        .xtalSlowRequest(1'b0), .systemReset(systemReset),
        .debugReset(debugReset), .factoryTestMode(), .first_digital_pin(),
        .hsSourceSelect(hsSourceSelect), .rtcEnable(rtcEnable),
        .calFastStart(calFastStart), .calSlowStart(), .clockIrq(clockIrq),
        .debugPortClockGate(debugPortClockGate),
        .system_clock_divided(system_clock_divided),
        .periphClockEnable(periphClockEnable), .boostFast(boostFast),
        .boostSlow());

    // 125 MHz system clock
    initial forever #4 clk_sys = ~clk_sys;

    // event counters and hang guard
    always @(posedge clk_sys) begin
        cyc++;
        startCnt += calFastStart;
        divCnt += system_clock_divided;
        perCnt += periphClockEnable[0];
        if (cyc > 90000) begin
            fails++;
            summarize();
        end
    end

    // compare one 32-bit result
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task apbXfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task apbWr(input logic [31:0] a, input logic [31:0] d);
        apbXfer(1'b1, a, d);
    endtask

    task apbRd(input logic [31:0] a);
        apbXfer(1'b0, a, 32'h0);
    endtask

    // wait for the reset stretch to finish
    task waitIdle();
        int n;
        n = 0;
        repeat (4) @(posedge clk_sys);
        while (systemReset !== 1'b0 && n < 500) begin
            @(posedge clk_sys);
            n++;
        end
        chk({31'h0, systemReset}, 32'h0);
    endtask

    task summarize();
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        waitIdle();
        apbRd(ADDR_RESET_CAUSE); chk(rd, 32'h10);
        chk(periphClockEnable, 32'h0);
        apbRd(ADDR_PERIPH_GATE); chk(rd, 32'hFFFF_FFFF);
        apbRd(ADDR_PRESCALER); chk(rd, 32'h3);
        apbRd(ADDR_RESET_REACH); chk(rd, 32'h0);
        apbRd(32'h4001_9000); chk({31'h0, err}, 32'h1);
        apbWr(ADDR_RESET_CAUSE_CLEAR, 32'h5A);
        apbRd(ADDR_RESET_CAUSE); chk(rd, 32'h0);
        // lockup only flags
        @(posedge clk_sys) lockup <= 1'b1;
        @(posedge clk_sys) lockup <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk({31'h0, systemReset}, 32'h0);
        apbRd(ADDR_RESET_CAUSE); chk(rd, 32'h1);
        // divide by two, peripheral follows
        apbWr(ADDR_PERIPH_GATE, 32'hFFFF_FFFE);
        apbWr(ADDR_PRESCALER, 32'h1);
        repeat (4) @(negedge clk_sys);
        sDiv = divCnt;
        sPer = perCnt;
        repeat (16) @(negedge clk_sys);
        chk(divCnt - sDiv, 32'd8);
        chk(perCnt - sPer, 32'd8);
        // clock control, calibration and interrupts
        apbWr(ADDR_CLOCK_IRQ_ENABLE, 32'h3);
        apbRd(ADDR_CLOCK_IRQ_ENABLE); chk(rd, 32'h3);
        @(negedge clk_sys) sStart = startCnt;
        apbWr(ADDR_CLOCK_CONTROL, 32'h1B);
        repeat (3) @(negedge clk_sys);
        chk(startCnt - sStart, 32'd1);
        chk({29'h0, rtcEnable, debugPortClockGate, hsSourceSelect}, 32'h7);
        chk({31'h0, boostFast}, 32'h1);
        apbRd(ADDR_CLOCK_CONTROL); chk(rd, 32'h13);
        @(posedge clk_sys);
        pins.xtalFastStable <= 1'b1;
        pins.factoryTestPin <= 1'b1;
        calFD <= 1'b1;
        calFF <= 1'b1;
        calSD <= 1'b1;
        @(posedge clk_sys);
        calFD <= 1'b0;
        calFF <= 1'b0;
        calSD <= 1'b0;
        repeat (8) @(negedge clk_sys);
        chk({31'h0, boostFast}, 32'h0);
        chk({31'h0, clockIrq}, 32'h1);
        apbRd(ADDR_CLOCK_STATUS); chk(rd, 32'h8000_0039);
        apbWr(ADDR_CLOCK_IRQ_CLEAR, 32'hA5);
        repeat (3) @(negedge clk_sys);
        chk({31'h0, clockIrq}, 32'h0);
        apbRd(ADDR_CLOCK_STATUS); chk(rd, 32'h8000_0001);
        apbWr(ADDR_CLOCK_CONTROL, 32'h0);
        apbRd(ADDR_CLOCK_CONTROL); chk(rd, 32'h2);
        // software reset
        apbWr(ADDR_RESET_CAUSE_CLEAR, 32'h0);
        @(posedge clk_sys) softReq <= 1'b1;
        @(posedge clk_sys) softReq <= 1'b0;
        waitIdle();
        apbRd(ADDR_RESET_CAUSE); chk(rd, 32'h8);
        // pin reset sparing debug logic
        apbWr(ADDR_RESET_REACH, 32'h1);
        apbWr(ADDR_RESET_CAUSE_CLEAR, 32'h0);
        @(posedge clk_sys) pins.externalResetPinN <= 1'b0;
        repeat (30) @(negedge clk_sys);
        chk({31'h0, systemReset}, 32'h1);
        chk({31'h0, debugReset}, 32'h0);
        @(posedge clk_sys) pins.externalResetPinN <= 1'b1;
        waitIdle();
        apbRd(ADDR_RESET_CAUSE); chk(rd, 32'h4);
        // watchdog: lock, pause under debugger, then overflow reset
        apbWr(ADDR_PERIPH_GATE, 32'hFFFF_FBFE);
        apbWr(ADDR_WDOG_CONTROL, 32'h3);
        apbWr(ADDR_WDOG_CONTROL, 32'h0);
        apbRd(ADDR_WDOG_CONTROL); chk(rd, 32'h3);
        apbWr(ADDR_RESET_CAUSE_CLEAR, 32'h0);
        @(posedge clk_sys) dbg <= 1'b1;
        repeat (4000) @(posedge clk_sys);
        dbg <= 1'b0;
        chk({31'h0, systemReset}, 32'h0);
        sStart = 0;
        while (systemReset !== 1'b1 && sStart < 70000) begin
            @(posedge clk_sys);
            sStart++;
        end
        chk({31'h0, systemReset}, 32'h1);
        waitIdle();
        apbRd(ADDR_RESET_CAUSE); chk(rd, 32'h2);
        summarize();
    end
endmodule
